// ===== logic/srt_regs.svh
// Timing constants for the supply reset timer
`ifndef SRT_REGS_SVH
`define SRT_REGS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define SRT_CLK_NS          25
`define SRT_CLK_HZ          40000000

// ----------------------------------------
// Assert delay and glitch filter
// ----------------------------------------
`define SRT_ASSERT_MAX_US   10
`define SRT_GLITCH_NS       5000
// Glitch window rounded down, kept below the assert limit
`define SRT_GLITCH_CYC      (`SRT_GLITCH_NS / `SRT_CLK_NS)

// ----------------------------------------
// Hold interval minimums in microseconds
// ----------------------------------------
`define SRT_HOLD_SHORT_US   1000
`define SRT_HOLD_MEDIUM_US  20000
`define SRT_HOLD_LONG_US    100000
`define SRT_HOLD_DEFAULT_US 140000

`endif

// ===== logic/srt_pkg.sv
// Types shared by the supply reset timer
package srt_pkg;

  // ----------------------------------------
  // Hold interval build options
  // ----------------------------------------
  typedef enum logic [1:0] {
    srt_short_hold_option,
    srt_medium_hold_option,
    srt_long_hold_option,
    srt_default_hold_option
  } srt_hold_type;

  // ----------------------------------------
  // Open-drain reset pin
  // ----------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
  } srt_od_pin_type;

endpackage

// ===== logic/srt_sync.sv
// Two-flop synchroniser for the supply comparator level
`timescale 1ns/1ps
`default_nettype none

module srt_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  // Reset value 1: treat supply as low until proven good
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1   <= 1'h1;
      sync_out <= 1'h1;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

`default_nettype wire

// ===== logic/srt_supply_reset_timer.sv
// Supply reset timer: holds the host in reset through supply faults
`timescale 1ns/1ps
`default_nettype none
`include "srt_regs.svh"

module srt_supply_reset_timer #(
  parameter srt_pkg::srt_hold_type HOLD_OPTION = srt_pkg::srt_default_hold_option,
  parameter int unsigned           HOLD_SHORT_US   = `SRT_HOLD_SHORT_US,
  parameter int unsigned           HOLD_MEDIUM_US  = `SRT_HOLD_MEDIUM_US,
  parameter int unsigned           HOLD_LONG_US    = `SRT_HOLD_LONG_US,
  parameter int unsigned           HOLD_DEFAULT_US = `SRT_HOLD_DEFAULT_US,
  parameter int unsigned           GLITCH_CYC      = `SRT_GLITCH_CYC
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset,
  // Supply comparator, high while below trip_level
  input  wire logic            supply_below,
  // Open-drain reset pin to the host
  input  wire logic            host_reset_n_in,
  output srt_pkg::srt_od_pin_type host_reset_n,
  // Status
  output logic                 osc_running
);

  // ----------------------------------------
  // Build-time hold count
  // ----------------------------------------
  function automatic int unsigned us_to_cyc(input int unsigned us);
    return us * (`SRT_CLK_HZ / 1000000);
  endfunction

  localparam int unsigned HOLD_US =
    (HOLD_OPTION == srt_pkg::srt_short_hold_option)  ? HOLD_SHORT_US  :
    (HOLD_OPTION == srt_pkg::srt_medium_hold_option) ? HOLD_MEDIUM_US :
    (HOLD_OPTION == srt_pkg::srt_long_hold_option)   ? HOLD_LONG_US   :
                                                       HOLD_DEFAULT_US;
  localparam int unsigned HOLD_CYC = us_to_cyc(HOLD_US);
  localparam int unsigned CW       = $clog2(HOLD_CYC + 1);
  localparam int unsigned GW       = $clog2(GLITCH_CYC + 1);
  localparam int unsigned ASSERT_MAX_CYC = us_to_cyc(`SRT_ASSERT_MAX_US);

  typedef enum logic [1:0] {
    srt_released,
    srt_asserted,
    srt_counting
  } srt_state_type;

  // ----------------------------------------
  // Supply level crossing
  // ----------------------------------------
  logic below_sync;

  srt_sync u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (supply_below),
    .sync_out (below_sync)
  );

  // ----------------------------------------
  // Glitch filter and state
  // ----------------------------------------
  srt_state_type state;
  srt_state_type next_state;
  logic [GW-1:0] dip_cnt;
  logic [GW-1:0] next_dip_cnt;
  logic [CW-1:0] hold_cnt;
  logic [CW-1:0] next_hold_cnt;
  logic          dip_long;

  // Dip counts as a fault only once it outlasts the glitch window
  assign dip_long = below_sync && (dip_cnt == GW'(GLITCH_CYC));

  always_comb begin
    next_state    = state;
    next_dip_cnt  = dip_cnt;
    next_hold_cnt = hold_cnt;
    if (!below_sync) begin
      next_dip_cnt = '0;
    end else if (dip_cnt != GW'(GLITCH_CYC)) begin
      next_dip_cnt = dip_cnt + GW'(1);
    end
    case (state)
      srt_released: begin
        next_hold_cnt = '0;
        if (dip_long) begin
          next_state = srt_asserted;
        end
      end
      srt_asserted: begin
        next_hold_cnt = '0;
        if (!below_sync) begin
          next_state = srt_counting;
        end
      end
      srt_counting: begin
        if (below_sync) begin
          next_state    = srt_asserted;
          next_hold_cnt = '0;
        end else if (hold_cnt == CW'(HOLD_CYC - 1)) begin
          next_state = srt_released;
        end else begin
          next_hold_cnt = hold_cnt + CW'(1);
        end
      end
      default: begin
        next_state    = srt_asserted;
        next_hold_cnt = '0;
      end
    endcase
  end

  // Power-up behaves as a recovery: reset held through a full count
  always_ff @(posedge mclk) begin
    if (reset) begin
      state    <= srt_asserted;
      dip_cnt  <= '0;
      hold_cnt <= '0;
    end else begin
      state    <= next_state;
      dip_cnt  <= next_dip_cnt;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pin only ever pulled low; the pull-up supplies the high level
  assign host_reset_n.out = 1'h0;
  assign host_reset_n.oe  = (state != srt_released);
  assign osc_running      = (state == srt_counting);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_fault_seen;
    $rose(dip_long);
  endsequence

  sequence s_recovered;
    (state == srt_asserted) && !below_sync;
  endsequence

  // Age of the synced dip; the synchroniser holds two more cycles of it.
  // A short dip never ages this far, so the filter cannot trip the bound.
  localparam int unsigned AW = $clog2(ASSERT_MAX_CYC + 1);
  logic [AW-1:0] below_age;
  logic [AW-1:0] next_below_age;

  always_comb begin
    next_below_age = below_age;
    if (!below_sync) begin
      next_below_age = '0;
    end else if (below_age != AW'(ASSERT_MAX_CYC)) begin
      next_below_age = below_age + AW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      below_age <= '0;
    end else begin
      below_age <= next_below_age;
    end
  end

  a_assert_on_fault: assert property (@(posedge mclk) disable iff (reset)
    s_fault_seen |=> host_reset_n.oe)
    else $error("reset pin not pulled low after fault");

  a_assert_bound: assert property (@(posedge mclk) disable iff (reset)
    below_age >= AW'(ASSERT_MAX_CYC - 2) |-> host_reset_n.oe)
    else $error("reset assert exceeded bound");

  a_hold_while_low: assert property (@(posedge mclk) disable iff (reset)
    state != srt_released && below_sync |=> host_reset_n.oe)
    else $error("reset released while supply low");

  a_release_stays: assert property (@(posedge mclk) disable iff (reset)
    state == srt_released && !below_sync |=> !host_reset_n.oe)
    else $error("reset asserted with good supply");

  a_count_starts: assert property (@(posedge mclk) disable iff (reset)
    s_recovered |=> osc_running && hold_cnt == '0)
    else $error("count did not start on recovery");

  a_full_count: assert property (@(posedge mclk) disable iff (reset)
    $fell(host_reset_n.oe) |-> $past(hold_cnt) == CW'(HOLD_CYC - 1))
    else $error("reset released before full count");

  a_drive_low_only: assert property (@(posedge mclk) disable iff (reset)
    host_reset_n.oe |-> !host_reset_n.out)
    else $error("reset pin driven high");

  a_glitch_ignored: assert property (@(posedge mclk) disable iff (reset)
    state == srt_released && below_sync && dip_cnt < GW'(GLITCH_CYC) |=>
      !host_reset_n.oe)
    else $error("short dip caused a reset");

  a_relapse_clears: assert property (@(posedge mclk) disable iff (reset)
    osc_running && below_sync |=> state == srt_asserted && hold_cnt == '0)
    else $error("relapse did not clear the count");

  initial begin
    if (GLITCH_CYC + 3 > ASSERT_MAX_CYC) begin
      $error("glitch window exceeds assert limit");
    end
  end

endmodule

`default_nettype wire

// ===== verification/srt_host_model.sv
// Host reset input of the supply reset timer, with its board pull-up
`timescale 1ns/1ps
`default_nettype none

module srt_host_model (
  // Pin from the timer
  input  wire srt_pkg::srt_od_pin_type pin,
  // Level seen by the host
  output logic                         line,
  output logic                         in_reset
);
  // Released pin floats up to the pull-up, never to the last value
  assign line     = pin.oe ? pin.out : 1'h1;
  assign in_reset = ~line;
endmodule

`default_nettype wire

// ===== verification/srt_supply_reset_timer_bench.sv
// Self-checking bench for the supply reset timer
`timescale 1ns/1ps
`default_nettype none

module srt_supply_reset_timer_bench;
  // ----------------------------------------
  // Setup: short holds and filter keep the run brief
  // ----------------------------------------
  // Hold lengths at 40 cycles per microsecond: 2, 1, 3 and 4 us
  localparam int HOLD_CYC   = 80;
  localparam int SHORT_CYC  = 40;
  localparam int MEDIUM_CYC = 120;
  localparam int LONG_CYC   = 160;
  // Assert limit of 10 us in cycles
  localparam int ASSERT_CYC = 400;
  logic                    mclk         = 1'h0;
  logic                    reset        = 1'h1;
  logic                    supply_below = 1'h0;
  logic                    line;
  logic                    in_reset;
  logic                    osc_running;
  srt_pkg::srt_od_pin_type pin;
  srt_pkg::srt_od_pin_type opt_pin [3];
  logic                    opt_line [3];
  logic                    opt_osc [3];
  logic                    aborted      = 1'h0;
  int                      n_fail       = 0;
  int                      checks       = 0;
  int                      n;

  always #12.5 mclk = ~mclk;

  srt_supply_reset_timer #(.HOLD_OPTION(srt_pkg::srt_default_hold_option),
    .HOLD_SHORT_US(1), .HOLD_MEDIUM_US(3), .HOLD_LONG_US(4), .HOLD_DEFAULT_US(2),
    .GLITCH_CYC(4)) DUT (
    .mclk(mclk), .reset(reset), .supply_below(supply_below),
    .host_reset_n_in(line), .host_reset_n(pin), .osc_running(osc_running));
  srt_host_model host (.pin(pin), .line(line), .in_reset(in_reset));

  // Other build options share the supply input; distinct lengths expose a wrong pick
  srt_supply_reset_timer #(.HOLD_OPTION(srt_pkg::srt_short_hold_option),
    .HOLD_SHORT_US(1), .HOLD_MEDIUM_US(3), .HOLD_LONG_US(4), .HOLD_DEFAULT_US(2),
    .GLITCH_CYC(4)) opt_short (
    .mclk(mclk), .reset(reset), .supply_below(supply_below),
    .host_reset_n_in(opt_line[0]), .host_reset_n(opt_pin[0]), .osc_running(opt_osc[0]));
  srt_host_model host_short (.pin(opt_pin[0]), .line(opt_line[0]), .in_reset());
  srt_supply_reset_timer #(.HOLD_OPTION(srt_pkg::srt_medium_hold_option),
    .HOLD_SHORT_US(1), .HOLD_MEDIUM_US(3), .HOLD_LONG_US(4), .HOLD_DEFAULT_US(2),
    .GLITCH_CYC(4)) opt_medium (
    .mclk(mclk), .reset(reset), .supply_below(supply_below),
    .host_reset_n_in(opt_line[1]), .host_reset_n(opt_pin[1]), .osc_running(opt_osc[1]));
  srt_host_model host_medium (.pin(opt_pin[1]), .line(opt_line[1]), .in_reset());
  srt_supply_reset_timer #(.HOLD_OPTION(srt_pkg::srt_long_hold_option),
    .HOLD_SHORT_US(1), .HOLD_MEDIUM_US(3), .HOLD_LONG_US(4), .HOLD_DEFAULT_US(2),
    .GLITCH_CYC(4)) opt_long (
    .mclk(mclk), .reset(reset), .supply_below(supply_below),
    .host_reset_n_in(opt_line[2]), .host_reset_n(opt_pin[2]), .osc_running(opt_osc[2]));
  srt_host_model host_long (.pin(opt_pin[2]), .line(opt_line[2]), .in_reset());

  task automatic check(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic check_count(input int got, input int exp, input string msg);
    checks++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s: got %0d expected %0d", $time, msg, got, exp);
    end
  endtask

  // A used-up bound counts as a mismatch; the later scenarios are skipped before the report
  task automatic give_up(input string msg);
    n_fail++;
    aborted = 1'h1;
    $display("CHECK FAILED %0t timed out: %s", $time, msg);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic drive(input logic v);
    @(posedge mclk);
    supply_below <= v;
    #1;
  endtask

  // Cycles of counting; the pin must stay low throughout
  task automatic hold_count(output int c);
    int w;
    w = 0;
    c = 0;
    while (osc_running !== 1'h1 && w < 20) begin
      step(1);
      w++;
    end
    if (osc_running !== 1'h1) begin
      give_up("count never started");
    end
    while (osc_running === 1'h1 && c < 1000) begin
      check(line, 1'h0, "released mid count");
      step(1);
      c++;
    end
    if (osc_running === 1'h1) begin
      give_up("count never ended");
    end
  endtask

  task automatic wait_assert(output int c);
    c = 0;
    while (in_reset !== 1'h1 && c < ASSERT_CYC) begin
      step(1);
      c++;
    end
    if (in_reset !== 1'h1) begin
      give_up("reset never asserted");
    end
  endtask

  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // All four options count their power-up hold side by side
  task automatic t_power_up;
    int c [4];
    for (int i = 0; i < 4; i++) begin
      c[i] = 0;
    end
    check(line, 1'h0, "pin high in reset");
    repeat (200) begin
      step(1);
      if (osc_running === 1'h1) begin
        c[0]++;
        check(line, 1'h0, "released mid count");
      end
      for (int i = 0; i < 3; i++) begin
        if (opt_osc[i] === 1'h1) begin
          c[i + 1]++;
        end
      end
    end
    check_count(c[0], HOLD_CYC, "default option hold length");
    check_count(c[1], SHORT_CYC, "short option hold length");
    check_count(c[2], MEDIUM_CYC, "medium option hold length");
    check_count(c[3], LONG_CYC, "long option hold length");
    check(line, 1'h1, "pin not released");
    check(osc_running, 1'h0, "oscillator left on");
    for (int i = 0; i < 3; i++) begin
      check(opt_line[i], 1'h1, "option pin not released");
    end
    $display("t_power_up done");
  endtask

  // Stays below past the assert limit so the bound check is exercised
  task automatic t_fault;
    drive(1'h1);
    wait_assert(n);
    check(logic'(n <= ASSERT_CYC), 1'h1, "assert later than 10 us");
    step(ASSERT_CYC);
    check(line, 1'h0, "pin released while below");
    check(osc_running, 1'h0, "count runs while below");
    drive(1'h0);
    hold_count(n);
    check_count(n, HOLD_CYC, "hold length");
    check(line, 1'h1, "pin not released after hold");
    $display("t_fault done");
  endtask

  // Dip exactly as long as the four-cycle filter window
  task automatic t_glitch;
    drive(1'h1);
    step(3);
    drive(1'h0);
    repeat (20) begin
      step(1);
      check(line, 1'h1, "short dip gave reset");
    end
    $display("t_glitch done");
  endtask

  // Relapse mid count must restart the full hold
  task automatic t_relapse;
    drive(1'h1);
    wait_assert(n);
    drive(1'h0);
    step(40);
    check(osc_running, 1'h1, "count not running");
    drive(1'h1);
    drive(1'h0);
    n = 0;
    while (line !== 1'h1 && n < 1000) begin
      step(1);
      n++;
    end
    if (line !== 1'h1) begin
      give_up("reset never released after relapse");
    end
    check(logic'(n >= HOLD_CYC && n <= HOLD_CYC + 8), 1'h1, "count not restarted");
    $display("t_relapse done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    #1;
    t_power_up();
    if (!aborted) t_fault();
    if (!aborted) t_glitch();
    if (!aborted) t_relapse();
    complete_run();
  end
endmodule

`default_nettype wire
